/* File: core/mft_consts.svh */
// Purpose: Named codes and values for the dual-counter timer
// Assumes: Included by bare name from core files
// Notes: Definitions only
`ifndef MFT_CONSTS_SVH
`define MFT_CONSTS_SVH

// Operating mode codes
`define MFT_MODE_PWM 2'h0
`define MFT_MODE_DCAP 2'h1
`define MFT_MODE_DTMR 2'h2
`define MFT_MODE_SCAP 2'h3

// Counter clock select codes
`define MFT_CSEL_STOP 3'h0
`define MFT_CSEL_PRESC 3'h1
`define MFT_CSEL_EVENT 3'h2
`define MFT_CSEL_PACC 3'h3
`define MFT_CSEL_SLOW 3'h4

// Values
`define MFT_PRESET_VAL 16'hffff
`define MFT_CNT_RST 16'h0000
`define MFT_PSC_RST 5'h00
`define MFT_PEND_RST 4'h0

// Pending and enable bit positions
`define MFT_SRC_A 0
`define MFT_SRC_B 1
`define MFT_SRC_C 2
`define MFT_SRC_D 3

`endif

/* File: core/mft_pkg.sv */
// Purpose: Types shared by the dual-counter timer files
// Assumes: Nothing
// Notes: Codes live in mft_consts.svh
package mft_pkg;

  // Static configuration from software
  typedef struct packed {
    logic [1:0] operating_mode_field;
    logic [2:0] counter_one_clock_select;
    logic [2:0] counter_two_clock_select;
    logic [4:0] prescale;
    logic pin_a_function_enable;
    logic pin_b_preset_enable;
    logic pin_a_rising;
    logic pin_b_rising;
    logic pin_a_out_init;
    logic [3:0] irq_enable;
  } mft_cfg_s;

  // Software writes to the data registers
  typedef struct packed {
    logic wr_counter_one;
    logic wr_counter_two;
    logic wr_reload_capture_a;
    logic wr_reload_capture_b;
    logic [15:0] data;
  } mft_wr_s;

endpackage

/* File: core/mft_edge.sv */
// Purpose: Edge detector with selectable polarity
// Assumes: Input already synchronous to i_clk
// Notes: Pulse is combinational from input and last sample
`timescale 1ns/100ps
module mft_edge (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Level in, edge select
  input wire logic i_level,
  input wire logic i_rising,
  // Edge pulse
  output logic o_pulse
);

  logic last_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      last_q <= 1'b0;
    else
      last_q <= i_level;
  end

  // Chosen edge only
  assign o_pulse = i_rising ? (i_level & ~last_q) : (~i_level & last_q);

endmodule

/* File: core/mft_counter.sv */
// Purpose: 16-bit down-counter with write, preset and reload
// Assumes: One tick enable per count step
// Notes: Write beats preset, preset beats counting
`timescale 1ns/100ps
`include "mft_consts.svh"
module mft_counter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_wr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_preset,
  input wire logic [15:0] i_reload,
  // Status
  output logic [15:0] o_count,
  output logic o_underflow
);

  logic [15:0] count_q;

  assign o_underflow = i_tick & ~i_wr & ~i_preset & (count_q == 16'h0000);
  assign o_count = count_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      count_q <= `MFT_CNT_RST;
    else if (i_wr)
      count_q <= i_wr_data;
    else if (i_preset)
      count_q <= `MFT_PRESET_VAL;
    else if (o_underflow)
      count_q <= i_reload;
    else if (i_tick)
      count_q <= count_q - 16'h0001;
  end

endmodule

/* File: core/mft_timer.sv */
// Purpose: Dual 16-bit timer with capture and dual-timer modes
// Assumes: Pin and slow clock inputs synchronous to i_clk
// Notes: Mode 00 runs counter one as in dual-timer mode
`timescale 1ns/100ps
`include "mft_consts.svh"

// How it works
// R01: Dual capture: counter one is capture base
// R02: Pin A/B edges copy counter one
// R03: Each capture pin has own edge select
// R04: Preset: store count, then load all ones
// R05: Pin levels held at least one clock
// R06: Dual capture: A, B, underflow interrupt events
// R07: Dual capture: counter two plain system timer
// R08: Capture modes: pin B clock stops counter
// R09: Counter one reloads from register A
// R10: Pin A toggles each counter one underflow
// R11: Pin A rising toggle sets source C
// R12: Pin B or prescaled clock drives counters
// R13: Counter two reloads B, sets source D
// R14: Single capture: pin B copies counter two
// R15: Single capture preset loads counter two ones
// R16: Single capture: pin B, underflow two events
// R17: Software keeps counter two clock running
// R18: Sources A-C to first, D to second
// R19: First interrupt line 14, second 13
// R20: Two-bit field selects operating mode
// R21: Three-bit clock select decode
// R22: Pending sticky until cleared; irq ORs them
module mft_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Configuration and software access
  input wire mft_pkg::mft_cfg_s i_cfg,
  input wire mft_pkg::mft_wr_s i_wr,
  input wire logic [3:0] i_interrupt_clear_register,
  // Timer pins and slow clock
  input wire logic i_timer_pin_a,
  input wire logic i_timer_pin_b,
  input wire logic i_slow_clk,
  // Pin A drive
  output logic o_timer_pin_a,
  output logic o_timer_pin_a_oe,
  // Register contents
  output logic [15:0] o_counter_one,
  output logic [15:0] o_counter_two,
  output logic [15:0] o_reload_capture_a,
  output logic [15:0] o_reload_capture_b,
  output logic [3:0] o_pending,
  // System interrupts
  output logic o_irq14,
  output logic o_irq13
);

  logic [4:0] psc_q;
  logic psc_tick;
  logic ev_b, cap_a, cap_b, slow_tick;
  logic m_dcap, m_scap, m_cap, m_tmr1;
  logic tick1, tick2, pre1, pre2, u1, u2;
  logic [15:0] cnt1, cnt2, rel1, rel2;
  logic [15:0] rca_q, rcb_q;
  logic pa_q, pa_oe_q, pa_rise;
  logic [3:0] pend_q, ev, en;
  logic irq14_q, irq13_q;

  // Mode decode
  assign m_dcap = i_cfg.operating_mode_field == `MFT_MODE_DCAP; // R20
  assign m_scap = i_cfg.operating_mode_field == `MFT_MODE_SCAP; // R20
  assign m_cap = m_dcap | m_scap;
  assign m_tmr1 = ~m_dcap;
  assign en = i_cfg.irq_enable;

  // Prescaler divides by value plus one
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      psc_q <= `MFT_PSC_RST;
    else if (psc_q == `MFT_PSC_RST)
      psc_q <= i_cfg.prescale;
    else
      psc_q <= psc_q - 5'h01;
  end
  assign psc_tick = psc_q == `MFT_PSC_RST;

  // Edge detectors
  mft_edge u_edge_a (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_timer_pin_a),
    .i_rising(i_cfg.pin_a_rising), // R03
    .o_pulse(cap_a)
  );

  mft_edge u_edge_b (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_timer_pin_b),
    .i_rising(i_cfg.pin_b_rising), // R03
    .o_pulse(ev_b)
  );

  // Slow clock must run well below i_clk to be seen
  mft_edge u_edge_slow (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_slow_clk),
    .i_rising(1'b1),
    .o_pulse(slow_tick)
  );

  assign cap_b = ev_b;

  // Clock select decode; reserved codes stop
  function automatic logic sel_tick(input logic [2:0] sel);
    logic t;
    t = 1'b0;
    case (sel)
      `MFT_CSEL_PRESC: t = psc_tick; // R21
      `MFT_CSEL_EVENT: t = ~m_cap & ev_b; // R08 R12
      `MFT_CSEL_PACC:
        t = ~m_cap & psc_tick & (i_timer_pin_b == i_cfg.pin_b_rising); // R08
      `MFT_CSEL_SLOW: t = slow_tick;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Process form so module signals read inside the function wake it
  always_comb
  begin
    tick1 = sel_tick(i_cfg.counter_one_clock_select); // R01 R09
    tick2 = sel_tick(i_cfg.counter_two_clock_select); // R07 R13
  end

  // Presets on capture events
  assign pre1 = m_dcap & ((cap_a & i_cfg.pin_a_function_enable) |
                (cap_b & i_cfg.pin_b_preset_enable)); // R04
  assign pre2 = m_scap & cap_b & i_cfg.pin_b_preset_enable; // R15

  // Capture bases wrap; counter two wraps outside dual-timer mode; other timers reload
  assign rel1 = m_dcap ? `MFT_PRESET_VAL : rca_q; // R09
  assign rel2 = (i_cfg.operating_mode_field == `MFT_MODE_DTMR) ?
                rcb_q : `MFT_PRESET_VAL; // R13

  mft_counter u_cnt_one (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick1),
    .i_wr(i_wr.wr_counter_one),
    .i_wr_data(i_wr.data),
    .i_preset(pre1),
    .i_reload(rel1),
    .o_count(cnt1),
    .o_underflow(u1)
  );

  mft_counter u_cnt_two (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick2),
    .i_wr(i_wr.wr_counter_two),
    .i_wr_data(i_wr.data),
    .i_preset(pre2),
    .i_reload(rel2),
    .o_count(cnt2),
    .o_underflow(u2)
  );

  // Capture beats a software write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rca_q <= `MFT_CNT_RST;
    else if (m_dcap & cap_a)
      rca_q <= cnt1; // R02
    else if (i_wr.wr_reload_capture_a)
      rca_q <= i_wr.data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rcb_q <= `MFT_CNT_RST;
    else if (m_dcap & cap_b)
      rcb_q <= cnt1; // R02
    else if (m_scap & cap_b)
      rcb_q <= cnt2; // R14
    else if (i_wr.wr_reload_capture_b)
      rcb_q <= i_wr.data;
  end

  // Pin A output holds initial level while counter one stopped
  assign pa_rise = m_tmr1 & i_cfg.pin_a_function_enable & u1 & ~pa_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pa_q <= 1'b0;
      pa_oe_q <= 1'b0;
    end
    else
    begin
      pa_oe_q <= m_tmr1 & i_cfg.pin_a_function_enable;
      if (~(m_tmr1 & i_cfg.pin_a_function_enable) ||
          i_cfg.counter_one_clock_select == `MFT_CSEL_STOP)
        pa_q <= i_cfg.pin_a_out_init;
      else if (u1)
        pa_q <= ~pa_q; // R10
    end
  end

  // Interrupt events per mode
  always_comb
  begin
    ev = 4'h0;
    ev[`MFT_SRC_A] = m_dcap ? cap_a : u1; // R06
    ev[`MFT_SRC_B] = m_cap & cap_b; // R06 R16
    ev[`MFT_SRC_C] = m_dcap ? u1 : pa_rise; // R06 R11
    ev[`MFT_SRC_D] = u2; // R07 R13 R16
  end

  // Set wins over clear
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pend_q <= `MFT_PEND_RST;
    else
      pend_q <= (pend_q & ~i_interrupt_clear_register) | ev; // R22
  end

  // Source C uses pin A enable outside dual capture
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      irq14_q <= 1'b0;
      irq13_q <= 1'b0;
    end
    else
    begin
      irq14_q <= (pend_q[`MFT_SRC_A] & en[`MFT_SRC_A]) |
                 (pend_q[`MFT_SRC_B] & en[`MFT_SRC_B]) |
                 (pend_q[`MFT_SRC_C] &
                  (m_dcap ? en[`MFT_SRC_C] : en[`MFT_SRC_A])); // R18 R19
      irq13_q <= pend_q[`MFT_SRC_D] & en[`MFT_SRC_D]; // R18 R19
    end
  end

  assign o_timer_pin_a = pa_q;
  assign o_timer_pin_a_oe = pa_oe_q;
  assign o_counter_one = cnt1;
  assign o_counter_two = cnt2;
  assign o_reload_capture_a = rca_q;
  assign o_reload_capture_b = rcb_q;
  assign o_pending = pend_q;
  assign o_irq14 = irq14_q;
  assign o_irq13 = irq13_q;

  a_cap_a_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R02
    m_dcap && cap_a |=> rca_q == $past(cnt1))
    else $error("pin A capture lost");

  a_preset_one: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R04
    pre1 && !i_wr.wr_counter_one |=> cnt1 == `MFT_PRESET_VAL)
    else $error("counter one not preset");

  a_cap_b_two: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
    m_scap && cap_b |=> rcb_q == $past(cnt2))
    else $error("pin B capture of counter two lost");

  a_preset_two: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R15
    pre2 && !i_wr.wr_counter_two |=> cnt2 == `MFT_PRESET_VAL)
    else $error("counter two not preset");

  a_cap_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R08
    m_cap && i_cfg.counter_one_clock_select == `MFT_CSEL_EVENT &&
    !i_wr.wr_counter_one && !pre1 |=> $stable(cnt1))
    else $error("counter one ran on pin B in capture mode");

  a_reload_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R09
    m_tmr1 && u1 |=> cnt1 == $past(rca_q))
    else $error("counter one reload wrong");

  a_pin_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
    m_tmr1 && u1 && i_cfg.pin_a_function_enable &&
    i_cfg.counter_one_clock_select != `MFT_CSEL_STOP
    |=> pa_q != $past(pa_q))
    else $error("pin A did not toggle");

  a_src_c_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R11
    pa_rise |=> pend_q[`MFT_SRC_C] ##1 1'b1)
    else $error("source C not set on pin A rise");

  a_src_d_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R13
    u2 |=> pend_q[`MFT_SRC_D])
    else $error("source D not set on underflow");

  a_pend_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R22
    pend_q[`MFT_SRC_B] && !i_interrupt_clear_register[`MFT_SRC_B]
    |=> pend_q[`MFT_SRC_B])
    else $error("pending flag dropped without clear");

  a_irq_two: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R19
    pend_q[`MFT_SRC_D] && en[`MFT_SRC_D] |=> o_irq13)
    else $error("line 13 not raised");

endmodule

/* File: dv/mft_pin_model.sv */
// Purpose: Outside signals on the two timer pins
// Assumes: Caller works from the falling clock edge
// Notes: Pins are plain levels, no pull
`timescale 1ns/100ps
module mft_pin_model (
  // Clock
  input wire logic i_clk,
  // Pin levels
  output logic o_pin_a,
  output logic o_pin_b
);
  initial
  begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  end
  // Never shorter than one clock, or the edge may be missed
  task automatic drive(input logic a, input logic b, input int n);
    o_pin_a = a;
    o_pin_b = b;
    repeat (n < 1 ? 1 : n) @(negedge i_clk);
  endtask
endmodule

/* File: dv/test_dual_timer_capture_modes.sv */
// Purpose: Self-checking bench for the dual-counter timer
// Assumes: Inputs change on the falling edge
// Notes: Stopped or idle slow clock keeps captures exact
`timescale 1ns/100ps
module test_dual_timer_capture_modes;
  logic clk = 1'b0;
  logic rst = 1'b1;
  mft_pkg::mft_cfg_s cfg = '0;
  mft_pkg::mft_wr_s wr = '0;
  logic [3:0] clr = 4'h0;
  logic slow = 1'b0;
  logic pa_out, pa_oe, pa_wire, mdl_a, mdl_b, irq14, irq13;
  logic [15:0] cnt1, cnt2, ra, rb;
  logic [3:0] pend;
  logic [4:0] flags;
  int mismatches = 0;
  int tests_run = 0;
  int k;
  // Shared pin A wire
  assign pa_wire = pa_oe ? pa_out : mdl_a;
  assign flags = {pa_out, pend};
  initial
  begin
    forever #50 clk = ~clk;
  end
  mft_pin_model pm (.i_clk(clk), .o_pin_a(mdl_a), .o_pin_b(mdl_b));
  mft_timer uut (
    .i_clk(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_wr(wr),
    .i_interrupt_clear_register(clr), .i_timer_pin_a(pa_wire),
    .i_timer_pin_b(mdl_b), .i_slow_clk(slow), .o_timer_pin_a(pa_out),
    .o_timer_pin_a_oe(pa_oe), .o_counter_one(cnt1), .o_counter_two(cnt2),
    .o_reload_capture_a(ra), .o_reload_capture_b(rb), .o_pending(pend),
    .o_irq14(irq14), .o_irq13(irq13)
  );
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  // One-hot select: counter one, two, reload a, reload b
  task automatic wrreg(input logic [3:0] s, input logic [15:0] d);
    @(negedge clk);
    wr.data = d;
    {wr.wr_counter_one, wr.wr_counter_two,
     wr.wr_reload_capture_a, wr.wr_reload_capture_b} = s;
    @(negedge clk);
    wr = '0;
  endtask
  task automatic clear(input logic [3:0] b);
    @(negedge clk);
    clr = b;
    @(negedge clk);
    clr = 4'h0;
    @(negedge clk);
  endtask
  task automatic wait_flag(input int i);
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (flags[i] === 1'b1)
        return;
    end
    chk("wait", 16'h1, 16'h0);
    final_report();
  endtask
  task automatic s_reset();
    chk("cnt1", 16'h0, cnt1);
    chk("cnt2", 16'h0, cnt2);
    chk("outs", 16'h0, {pend, irq14, irq13, pa_oe});
  endtask
  task automatic s_dual_capture();
    @(negedge clk);
    cfg.operating_mode_field = 2'h1;
    cfg.pin_a_function_enable = 1'b1;
    cfg.pin_a_rising = 1'b1;
    cfg.irq_enable = 4'h3;
    wrreg(4'h8, 16'h1234);
    pm.drive(1'b1, 1'b1, 2);
    chk("ra", 16'h1234, ra);
    chk("cnt1", 16'hffff, cnt1);
    chk("oe", 16'h0, pa_oe);
    wrreg(4'h8, 16'h0042);
    pm.drive(1'b0, 1'b0, 2);
    chk("rb", 16'h0042, rb);
    chk("pend", 16'h3, pend);
    chk("irq", 16'h2, {irq14, irq13});
    clear(4'h3);
    chk("clr", 16'h0, {pend, irq14});
    wrreg(4'h8, 16'h0002);
    cfg.counter_one_clock_select = 3'h1;
    cfg.irq_enable = 4'h4;
    wait_flag(2);
    chk("cnt1", 16'hffff, cnt1);
    @(negedge clk);
    chk("irq14", 16'h1, irq14);
    cfg.counter_one_clock_select = 3'h0;
    clear(4'hf);
  endtask
  task automatic s_no_pin_clock();
    for (int m = 0; m < 2; m++)
    begin
      @(negedge clk);
      cfg.operating_mode_field = m ? 2'h3 : 2'h1;
      cfg.counter_one_clock_select = m ? 3'h3 : 3'h2;
      cfg.counter_two_clock_select = m ? 3'h4 : 3'h3;
      cfg.pin_b_rising = 1'b1;
      wrreg(4'h8, 16'h0005);
      wrreg(4'h4, 16'h0006);
      pm.drive(1'b0, 1'b1, 3);
      pm.drive(1'b0, 1'b0, 3);
      chk("cnt1", 16'h0005, cnt1);
      chk("cnt2", 16'h0006, cnt2);
    end
  endtask
  task automatic s_dual_timer();
    @(negedge clk);
    cfg.operating_mode_field = 2'h2;
    cfg.counter_one_clock_select = 3'h0;
    cfg.counter_two_clock_select = 3'h0;
    cfg.pin_a_out_init = 1'b0;
    cfg.irq_enable = 4'hd;
    wrreg(4'h2, 16'h0003);
    wrreg(4'h1, 16'h0002);
    wrreg(4'h8, 16'h0000);
    wrreg(4'h4, 16'h0000);
    clear(4'hf);
    chk("oe", 16'h1, pa_oe);
    cfg.counter_one_clock_select = 3'h1;
    cfg.counter_two_clock_select = 3'h1;
    wait_flag(3);
    chk("cnt1", 16'h0003, cnt1);
    chk("cnt2", 16'h0002, cnt2);
    chk("pa", 16'h1, pa_out);
    chk("pend", 16'hd, pend);
    k = 0;
    while (pa_out === 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk("period", 16'h4, k[15:0]);
    if (k >= 20)
      final_report();
    chk("irq", 16'h3, {irq14, irq13});
  endtask
  task automatic s_pin_b_clock();
    @(negedge clk);
    cfg.counter_one_clock_select = 3'h0;
    cfg.counter_two_clock_select = 3'h0;
    wrreg(4'h8, 16'h0100);
    wrreg(4'h4, 16'h000a);
    cfg.counter_one_clock_select = 3'h3;
    cfg.counter_two_clock_select = 3'h2;
    repeat (3)
    begin
      pm.drive(1'b0, 1'b1, 2);
      pm.drive(1'b0, 1'b0, 2);
    end
    chk("cnt2", 16'h0007, cnt2);
    chk("cnt1", 16'h00fa, cnt1);
    cfg.counter_one_clock_select = 3'h0;
    cfg.counter_two_clock_select = 3'h4;
    // Slow clock kept at a fifth of the system rate
    repeat (2)
    begin
      @(negedge clk);
      slow = 1'b1;
      repeat (2) @(negedge clk);
      slow = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
    chk("cnt2", 16'h0005, cnt2);
    // Divide by four: eight cycles give two steps
    cfg.counter_two_clock_select = 3'h0;
    wrreg(4'h4, 16'h0010);
    cfg.prescale = 5'h03;
    cfg.counter_two_clock_select = 3'h1;
    repeat (8) @(negedge clk);
    chk("cnt2", 16'h000e, cnt2);
    cfg.prescale = 5'h00;
    cfg.counter_two_clock_select = 3'h4;
  endtask
  task automatic s_single_capture();
    @(negedge clk);
    cfg.operating_mode_field = 2'h3;
    cfg.pin_a_function_enable = 1'b0;
    cfg.pin_b_rising = 1'b0;
    cfg.pin_b_preset_enable = 1'b1;
    cfg.irq_enable = 4'ha;
    wrreg(4'h4, 16'h0777);
    clear(4'hf);
    pm.drive(1'b0, 1'b1, 2);
    pm.drive(1'b0, 1'b0, 2);
    chk("rb", 16'h0777, rb);
    chk("cnt2", 16'hffff, cnt2);
    chk("pend", 16'h2, pend);
    chk("irq14", 16'h1, irq14);
    wrreg(4'h4, 16'h0001);
    cfg.counter_two_clock_select = 3'h1;
    wait_flag(3);
    chk("cnt2", 16'hffff, cnt2);
    @(negedge clk);
    chk("irq13", 16'h1, irq13);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_dual_capture();
    s_no_pin_clock();
    s_dual_timer();
    s_pin_b_clock();
    s_single_capture();
    final_report();
  end
endmodule
